// File: diag_pkg.sv
// diagnostics and event-counter handler: shared constants, register map and carrier types
// assumes a frame decoder upstream that delivers parsed requests and line event pulses

package diag_pkg;

   // ------------------------------------------------------------------
   // function and sub-function codes
   // ------------------------------------------------------------------
   localparam logic [7:0]  FN_DIAG    = 8'h08;
   localparam logic [7:0]  FN_EVCNT   = 8'h0b;
   localparam logic [15:0] SF_RESTART = 16'h0001;
   localparam logic [15:0] SF_DELIM   = 16'h0003;
   localparam logic [15:0] SF_LISTEN  = 16'h0004;
   localparam logic [15:0] SF_CLEAR   = 16'h000a;
   localparam logic [15:0] SF_CNT_LO  = 16'h000b;
   localparam logic [15:0] SF_CNT_HI  = 16'h0012;
   localparam logic [15:0] SF_CLROVR  = 16'h0014;
   localparam logic [15:0] DATA_ZERO  = 16'h0000;

   // ------------------------------------------------------------------
   // reset values and fixed words
   // ------------------------------------------------------------------
   localparam logic [7:0]  DELIM_RST   = 8'h0a;
   localparam logic [7:0]  EVT_LISTEN  = 8'h04;
   localparam logic [15:0] STATUS_BUSY = 16'hffff;
   localparam logic [15:0] STATUS_IDLE = 16'h0000;
   localparam logic [15:0] CNT_RST     = 16'h0000;

   // statistics counter indices, in sub-function order
   localparam int N_CNT     = 8;
   localparam int CNT_BUS   = 0;
   localparam int CNT_CRC   = 1;
   localparam int CNT_EXC   = 2;
   localparam int CNT_SRV   = 3;
   localparam int CNT_NORSP = 4;
   localparam int CNT_NAK   = 5;
   localparam int CNT_BUSY  = 6;
   localparam int CNT_OVR   = 7;

   // ------------------------------------------------------------------
   // register map (byte addresses)
   // ------------------------------------------------------------------
   localparam logic [7:0] A_CTRL     = 8'h00;
   localparam logic [7:0] A_STAT     = 8'h04;
   localparam logic [7:0] A_EVCNT    = 8'h08;
   localparam logic [7:0] A_DIAG     = 8'h0c;
   localparam logic [7:0] A_CNT_BASE = 8'h10;
   localparam logic [7:0] A_CNT_LAST = 8'h2c;
   localparam int CTRL_BUSY_BIT  = 0;
   localparam int STAT_LISTEN_BIT = 0;
   localparam int STAT_TXEN_BIT  = 1;
   localparam int STAT_OVR_BIT   = 2;
   localparam int STAT_DELIM_LSB = 8;

   // ------------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------------
   typedef struct packed {
      logic [7:0]  func;
      logic [15:0] sub;
      logic [15:0] data;
      logic        bcast;
   } req_t;

   typedef struct packed {
      logic [7:0]  func;
      logic [15:0] w0;
      logic [15:0] w1;
   } rsp_t;

   typedef struct packed {
      logic bus_frame;
      logic crc_err;
      logic exc_sent;
      logic nak_sent;
      logic busy_sent;
      logic no_resp;
      logic overrun;
      logic ok_done;
   } line_evt_t;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [7:0]  paddr;
      logic [31:0] pwdata;
   } apb_req_t;

endpackage

// File: diag_counter_handler.sv
// diagnostics sub-functions 01, 03, 04, 0a..12 and 14 (others forwarded) and event-counter fetch, with statistics and an apb register file
// assumes requests are already addressed to this server (or broadcast) and crc-checked upstream
//
// Overview of operation
// - sub-function 03 sets ascii end delimiter from first data byte, echoes request.
// - sub-function 04 with zero data enters listen only, no reply sent.
// - in listen only, addressed or broadcast frames other than restart are seen but neither acted on nor answered.
// - in listen only only the restart sub-function is acted on.
// - entering listen only turns transmit controls off and lets ready watchdog expire.
// - sub-function 0a with zero data clears all counters and diagnostic register, echoes.
// - all statistics counters are zero after reset.
// - sub-function 0b returns bus message count.
// - sub-function 0c returns crc error count.
// - sub-function 0d returns exception reply count.
// - sub-function 0e returns processed server message count.
// - sub-function 0f returns server no-response count.
// - sub-function 10 returns negative-acknowledge exception count.
// - sub-function 11 returns device-busy exception count.
// - sub-function 12 returns character overrun count.
// - sub-function 14 with zero data clears overrun counter and flag, echoes.
// - function 0b request is code only; reply carries status word then event count.
// - event counter counts successful completions, not exceptions, polls or fetches.
// - restart and clear-counters reset the event counter.
// - status word is all ones while a program command runs, else zeros.
// - restart reinitialises port, clears counters, leaves listen only, silent if it was.
// - a 16-bit diagnostic register exists and clear-counters resets it.
// - entering listen only records event byte 04.

`timescale 1ns/1ps

module diag_counter_handler (
   // clock, reset, enable
   input  wire  logic              sys_clk,
   input  wire  logic              rst_b,
   input  wire  logic              ce,
   // parsed request from the frame decoder
   input  wire  logic              req_valid,
   input  wire  diag_pkg::req_t    req,
   // line and completion events, one-cycle pulses
   input  wire  diag_pkg::line_evt_t evt,
   // normal reply to send
   output logic                    rsp_valid,
   output diag_pkg::rsp_t          rsp,
   // request handed on to the other function handlers
   output logic                    fwd_valid,
   output diag_pkg::req_t          fwd,
   // event byte to the event log
   output logic                    evt_valid,
   output logic [7:0]              evt_byte,
   // port control
   output logic                    port_restart,
   output logic                    listen_only,
   output logic                    tx_ctrl_en,
   output logic                    wdog_expire,
   output logic [7:0]              delim,
   // apb slave
   input  wire  diag_pkg::apb_req_t apb,
   output logic                    pready,
   output logic [31:0]             prdata,
   output logic                    pslverr
);

   // ------------------------------------------------------------------
   // state
   // ------------------------------------------------------------------
   typedef struct packed {
      logic                  listen;
      logic                  txen;
      logic [7:0]            delim;
      logic                  ovrflg;
      logic [7:0][15:0]      cnt;
      logic [15:0]           evcnt;
      logic [15:0]           diag;
      logic                  busy;
      logic                  rsp_valid;
      diag_pkg::rsp_t        rsp;
      logic                  fwd_valid;
      diag_pkg::req_t        fwd;
      logic                  evt_valid;
      logic [7:0]            evt_byte;
      logic                  restart;
      logic                  rdy;
      logic [31:0]           prdata;
      logic                  slverr;
   } state_t;

   state_t q;
   state_t d;

   // counter step: clear first so a same-cycle event still counts, then wrap on overflow
   function automatic logic [15:0] bump(input logic [15:0] v, input logic clr, input logic inc);
      logic [15:0] base;
      base = clr ? diag_pkg::CNT_RST : v;
      return base + {15'h0000, inc};
   endfunction

   // register decode; misaligned or out-of-map addresses are errors
   function automatic logic addr_ok(input logic [7:0] a);
      logic ok;
      ok = (a[1:0] == 2'b00) && (a <= diag_pkg::A_CNT_LAST);
      return ok;
   endfunction

   // ------------------------------------------------------------------
   // next state
   // ------------------------------------------------------------------
   logic                  acc;
   logic                  act;
   logic                  reply;
   logic                  ev_ok;
   logic                  clr_all;
   logic                  clr_ovr;
   logic                  srv_inc;
   logic                  nr_inc;
   logic [7:0]            inc;
   logic [15:0]           rw0;
   logic [15:0]           rw1;
   logic [2:0]            cidx;
   logic [15:0]           coff;
   logic                  is_restart;
   logic [7:0]            aoff;

   always_comb begin
      d          = q;
      d.rsp_valid = 1'b0;
      d.fwd_valid = 1'b0;
      d.evt_valid = 1'b0;
      d.restart  = 1'b0;
      reply      = 1'b0;
      ev_ok      = 1'b0;
      clr_all    = 1'b0;
      clr_ovr    = 1'b0;
      srv_inc    = 1'b0;
      nr_inc     = 1'b0;
      rw0        = req.sub;
      rw1        = req.data;
      coff       = req.sub - diag_pkg::SF_CNT_LO;
      cidx       = coff[2:0];
      is_restart = (req.func == diag_pkg::FN_DIAG) && (req.sub == diag_pkg::SF_RESTART);
      act        = req_valid && !(q.listen && !is_restart);

      // silent monitoring: frame is seen, only the no-response count steps (addressed frames), nothing sent
      if (req_valid && !act) begin
         nr_inc = !req.bcast;
      end

      if (act) begin
         srv_inc = 1'b1;
         if (req.func == diag_pkg::FN_DIAG) begin
            if (req.sub == diag_pkg::SF_RESTART) begin
               clr_all   = 1'b1;
               d.listen  = 1'b0;
               d.txen    = 1'b1;
               d.restart = 1'b1;
               reply     = !q.listen;
               nr_inc    = q.listen && !req.bcast;
            end else if (req.sub == diag_pkg::SF_DELIM) begin
               d.delim = req.data[15:8];
               reply   = 1'b1;
               ev_ok   = 1'b1;
            end else if (req.sub == diag_pkg::SF_LISTEN && req.data == diag_pkg::DATA_ZERO) begin
               d.listen    = 1'b1;
               d.txen      = 1'b0;
               d.evt_valid = 1'b1;
               d.evt_byte  = diag_pkg::EVT_LISTEN;
               nr_inc      = !req.bcast;
            end else if (req.sub == diag_pkg::SF_CLEAR && req.data == diag_pkg::DATA_ZERO) begin
               clr_all = 1'b1;
               reply   = 1'b1;
            end else if (req.sub >= diag_pkg::SF_CNT_LO && req.sub <= diag_pkg::SF_CNT_HI) begin
               rw1   = q.cnt[cidx];
               reply = 1'b1;
               ev_ok = 1'b1;
            end else if (req.sub == diag_pkg::SF_CLROVR && req.data == diag_pkg::DATA_ZERO) begin
               clr_ovr = 1'b1;
               reply   = 1'b1;
               ev_ok   = 1'b1;
            end else begin
               // other sub-functions and bad data belong to the general handler
               d.fwd_valid = 1'b1;
               d.fwd       = req;
            end
         end else if (req.func == diag_pkg::FN_EVCNT) begin
            rw0   = q.busy ? diag_pkg::STATUS_BUSY : diag_pkg::STATUS_IDLE;
            rw1   = q.evcnt;
            reply = 1'b1; // fetch does not count itself
         end else begin
            d.fwd_valid = 1'b1;
            d.fwd       = req;
         end
      end

      // broadcasts are processed but never answered
      if (reply) begin
         d.rsp_valid = !req.bcast;
         d.rsp.func  = req.func;
         d.rsp.w0    = rw0;
         d.rsp.w1    = rw1;
         nr_inc      = nr_inc || req.bcast;
      end

      // statistics: set wins over clear, every counter wraps at 16 bits
      inc = 8'h00;
      inc[diag_pkg::CNT_BUS]   = evt.bus_frame;
      inc[diag_pkg::CNT_CRC]   = evt.crc_err;
      inc[diag_pkg::CNT_EXC]   = evt.exc_sent;
      inc[diag_pkg::CNT_SRV]   = srv_inc;
      inc[diag_pkg::CNT_NORSP] = nr_inc || evt.no_resp;
      inc[diag_pkg::CNT_NAK]   = evt.nak_sent;
      inc[diag_pkg::CNT_BUSY]  = evt.busy_sent;
      inc[diag_pkg::CNT_OVR]   = evt.overrun;
      for (int i = 0; i < diag_pkg::N_CNT; i++) begin
         d.cnt[i] = bump(q.cnt[i], clr_all || (clr_ovr && i == diag_pkg::CNT_OVR), inc[i]);
      end
      d.ovrflg = (q.ovrflg && !clr_ovr) || evt.overrun;
      d.evcnt  = bump(q.evcnt, clr_all, ev_ok || evt.ok_done);
      if (clr_all) begin
         d.diag = diag_pkg::CNT_RST;
      end

      // apb: one wait state; data prepared first, write committed on the pready edge
      acc = apb.psel && apb.penable;
      // counter window starts at its base, so index by the offset from there
      aoff = apb.paddr - diag_pkg::A_CNT_BASE;
      d.rdy = 1'b0;
      if (acc && !q.rdy) begin
         d.rdy    = 1'b1;
         d.slverr = !addr_ok(apb.paddr);
         d.prdata = 32'h0000_0000;
         if (apb.paddr == diag_pkg::A_CTRL) begin
            d.prdata[diag_pkg::CTRL_BUSY_BIT] = q.busy;
         end else if (apb.paddr == diag_pkg::A_STAT) begin
            d.prdata[diag_pkg::STAT_LISTEN_BIT] = q.listen;
            d.prdata[diag_pkg::STAT_TXEN_BIT]   = q.txen;
            d.prdata[diag_pkg::STAT_OVR_BIT]    = q.ovrflg;
            d.prdata[diag_pkg::STAT_DELIM_LSB +: 8] = q.delim;
         end else if (apb.paddr == diag_pkg::A_EVCNT) begin
            d.prdata[15:0] = q.evcnt;
         end else if (apb.paddr == diag_pkg::A_DIAG) begin
            d.prdata[15:0] = q.diag;
         end else if (addr_ok(apb.paddr)) begin
            d.prdata[15:0] = q.cnt[aoff[4:2]];
         end
      end
      if (acc && q.rdy && apb.pwrite && !q.slverr) begin
         if (apb.paddr == diag_pkg::A_CTRL) begin
            d.busy = apb.pwdata[diag_pkg::CTRL_BUSY_BIT];
         end else if (apb.paddr == diag_pkg::A_DIAG) begin
            d.diag = apb.pwdata[15:0]; // software write wins over a same-cycle clear
         end
      end
   end

   // ------------------------------------------------------------------
   // state register
   // ------------------------------------------------------------------
   // synchronous reset; ce low freezes everything, including pending pulses
   always_ff @(posedge sys_clk) begin
      if (!rst_b) begin
         q          <= '0;
         q.txen     <= 1'b1;
         q.delim    <= diag_pkg::DELIM_RST;
      end else if (ce) begin
         q <= d;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign rsp_valid    = q.rsp_valid;
   assign rsp          = q.rsp;
   assign fwd_valid    = q.fwd_valid;
   assign fwd          = q.fwd;
   assign evt_valid    = q.evt_valid;
   assign evt_byte     = q.evt_byte;
   assign port_restart = q.restart;
   assign listen_only  = q.listen;
   assign tx_ctrl_en   = q.txen;
   assign wdog_expire  = q.listen;
   assign delim        = q.delim;
   assign pready       = q.rdy;
   assign prdata       = q.prdata;
   assign pslverr      = q.rdy && q.slverr;

   // ------------------------------------------------------------------
   // checks
   // ------------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_b);

   sequence diag_req_s(logic [15:0] sf);
      ce && req_valid && !q.listen && !req.bcast && req.func == diag_pkg::FN_DIAG && req.sub == sf;
   endsequence

   sequence listen_req_s;
      diag_req_s(diag_pkg::SF_LISTEN) ##0 req.data == diag_pkg::DATA_ZERO;
   endsequence

   sequence quiet_after_s;
      !rsp_valid && listen_only && !tx_ctrl_en && wdog_expire;
   endsequence

   delim_set_a: assert property (diag_req_s(diag_pkg::SF_DELIM) |=>
      delim == $past(req.data[15:8]) && rsp_valid && rsp.w1 == $past(req.data))
      else $error("delimiter not taken or not echoed");

   listen_enter_a: assert property (listen_req_s |=> quiet_after_s)
      else $error("listen only entry wrong");

   listen_event_a: assert property (listen_req_s |=> evt_valid && evt_byte == diag_pkg::EVT_LISTEN)
      else $error("listen only event byte missing");

   listen_quiet_a: assert property ((ce && req_valid && q.listen && !is_restart) |=>
      !rsp_valid && !fwd_valid && listen_only)
      else $error("acted on a frame in listen only");

   restart_exit_a: assert property ((ce && req_valid && q.listen && is_restart) |=>
      !listen_only && tx_ctrl_en && port_restart && !rsp_valid && q.evcnt == {15'h0000, $past(evt.ok_done)})
      else $error("restart from listen only wrong");

   clear_all_a: assert property ((diag_req_s(diag_pkg::SF_CLEAR) ##0 req.data == diag_pkg::DATA_ZERO
      ##0 evt == '0 && !(acc && q.rdy)) |=> q.cnt[diag_pkg::CNT_CRC] == 16'h0000 && q.diag == 16'h0000)
      else $error("clear counters did not clear");

   evcnt_fetch_a: assert property ((ce && req_valid && !q.listen && !req.bcast && req.func == diag_pkg::FN_EVCNT)
      |=> rsp_valid && rsp.w1 == $past(q.evcnt) && rsp.w0 == ($past(q.busy) ? 16'hffff : 16'h0000))
      else $error("event counter reply wrong");

   crc_read_a: assert property (diag_req_s(16'h000c) |=> rsp.w1 == $past(q.cnt[diag_pkg::CNT_CRC]))
      else $error("crc count read wrong");

   ovr_clear_a: assert property ((diag_req_s(diag_pkg::SF_CLROVR) ##0 req.data == diag_pkg::DATA_ZERO
      ##0 !evt.overrun) |=> !q.ovrflg && q.cnt[diag_pkg::CNT_OVR] == 16'h0000)
      else $error("overrun clear failed");

   cnt_wrap_a: assert property ((ce && evt.crc_err && q.cnt[diag_pkg::CNT_CRC] == 16'hffff && !clr_all)
      |=> q.cnt[diag_pkg::CNT_CRC] == 16'h0000)
      else $error("counter did not wrap");

   reset_zero_a: assert property ($rose(rst_b) |-> q.cnt == '0 && q.evcnt == 16'h0000)
      else $error("counters not zero after reset");

   apb_wait_a: assert property ((ce && acc && !q.rdy) |=> pready ##1 !pready)
      else $error("apb ready timing wrong");

   fetch_uncounted_a: assert property ((ce && req_valid && !q.listen && req.func == diag_pkg::FN_EVCNT
      && !evt.ok_done) |=> q.evcnt == $past(q.evcnt))
      else $error("event counter counted a fetch");

   srv_count_a: assert property ((ce && req_valid && !q.listen && !clr_all)
      |=> q.cnt[diag_pkg::CNT_SRV] == $past(q.cnt[diag_pkg::CNT_SRV]) + 16'h0001)
      else $error("server message count not stepped");

   nak_count_a: assert property ((ce && evt.nak_sent && !clr_all)
      |=> q.cnt[diag_pkg::CNT_NAK] == $past(q.cnt[diag_pkg::CNT_NAK]) + 16'h0001)
      else $error("nak count not stepped");

   silent_count_a: assert property ((ce && req_valid && q.listen && !is_restart && !req.bcast
      && !evt.no_resp) |=> q.cnt[diag_pkg::CNT_NORSP] == $past(q.cnt[diag_pkg::CNT_NORSP]) + 16'h0001)
      else $error("no-response count not stepped");

   listen_ctrl_a: assert property (listen_only |-> !tx_ctrl_en && wdog_expire)
      else $error("controls on in listen only");

   fwd_pass_a: assert property ((ce && req_valid && !q.listen && req.func == diag_pkg::FN_DIAG
      && req.sub == 16'h0002) |=> fwd_valid && !rsp_valid && fwd == $past(req))
      else $error("request not forwarded");

endmodule

// File: diag_client_model.sv
// far-side model: frame decoder and client, feeding parsed requests and line events
// assumes the bench calls its tasks from one process, after reset release
`timescale 1ns/1ps

module diag_client_model (
   // clock
   input  wire logic           sys_clk,
   // parsed requests and line events
   output diag_pkg::req_t      req,
   output logic                req_valid,
   output diag_pkg::line_evt_t evt
);
   // ---------------------------------------------------------------
   // idle lines
   // ---------------------------------------------------------------
   initial begin
      req_valid = 1'b0;
      req       = '0;
      evt       = '0;
   end

   // one request taken at the next edge; released fields are scrambled so nothing leans on stale values
   task automatic send(input logic [7:0] func, input logic [15:0] sub, input logic [15:0] data);
      diag_pkg::req_t r;
      r.func  = func;
      r.sub   = (func == diag_pkg::FN_EVCNT) ? 16'h0000 : sub;
      r.data  = (func == diag_pkg::FN_EVCNT) ? 16'h0000 : data;
      r.bcast = 1'b0;
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req       <= r;
      @(posedge sys_clk);
      req_valid <= 1'b0;
      req       <= ~r;
      #1;
   endtask

   // line events held n cycles, so one call can drive a counter past its wrap
   task automatic pulse(input diag_pkg::line_evt_t e, input int n);
      @(posedge sys_clk);
      evt <= e;
      repeat (n) @(posedge sys_clk);
      evt <= '0;
   endtask
endmodule

// File: serial_diag_counter_handler_tb.sv
// self-checking bench: requests through the client model, registers over apb
// assumes one 40 MHz clock and a synchronous active-low reset
`timescale 1ns/1ps

module serial_diag_counter_handler_tb;
   // ---------------------------------------------------------------
   // signals
   // ---------------------------------------------------------------
   logic                sys_clk = 1'b0;
   logic                rst_b   = 1'b0;
   logic                ce      = 1'b1;
   diag_pkg::req_t      req;
   logic                req_valid;
   diag_pkg::line_evt_t evt;
   logic                rsp_valid;
   diag_pkg::rsp_t      rsp;
   logic                fwd_valid;
   diag_pkg::req_t      fwd;
   logic                evt_valid;
   logic [7:0]          evt_byte;
   logic                port_restart;
   logic                listen_only;
   logic                tx_ctrl_en;
   logic                wdog_expire;
   logic [7:0]          delim;
   diag_pkg::apb_req_t  apb = '0;
   logic                pready;
   logic [31:0]         prdata;
   logic                pslverr;
   logic [31:0]         rd;
   logic                err;
   int                  fail_count = 0;
   int                  num_checks = 0;

   // 25 ns period
   always #12.5 sys_clk = ~sys_clk;

   diag_client_model diag_client_model_i (.sys_clk(sys_clk), .req(req), .req_valid(req_valid), .evt(evt));

   diag_counter_handler diag_counter_handler_i (
      .sys_clk(sys_clk), .rst_b(rst_b), .ce(ce), .req_valid(req_valid), .req(req), .evt(evt),
      .rsp_valid(rsp_valid), .rsp(rsp), .fwd_valid(fwd_valid), .fwd(fwd), .evt_valid(evt_valid),
      .evt_byte(evt_byte), .port_restart(port_restart), .listen_only(listen_only),
      .tx_ctrl_en(tx_ctrl_en), .wdog_expire(wdog_expire), .delim(delim), .apb(apb),
      .pready(pready), .prdata(prdata), .pslverr(pslverr));

   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // one apb transfer; waits for pready under a bound, result left in rd and err
   task automatic apb_xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wdata);
      int n;
      n = 0;
      @(posedge sys_clk);
      apb.psel    <= 1'b1;
      apb.penable <= 1'b0;
      apb.pwrite  <= wr;
      apb.paddr   <= addr;
      apb.pwdata  <= wdata;
      @(posedge sys_clk);
      apb.penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      err = pslverr;
      if (n >= 20) check("pready", 32'h0, 32'h1);
      apb.psel    <= 1'b0;
      apb.penable <= 1'b0;
   endtask

   // fetch the event counter and status word
   task automatic fetch(input logic [15:0] status, input logic [15:0] count);
      diag_client_model_i.send(diag_pkg::FN_EVCNT, 16'h0, 16'h0);
      check("fetch func", {rsp_valid, rsp.func}, {1'b1, diag_pkg::FN_EVCNT});
      check("status word", rsp.w0, status);
      check("event count", rsp.w1, count);
   endtask

   // diag request expecting an echo or a returned count
   task automatic diag(input logic [15:0] sub, input logic [15:0] data, input logic [15:0] exp);
      diag_client_model_i.send(diag_pkg::FN_DIAG, sub, data);
      check("diag reply", {rsp_valid, rsp.func, rsp.w0, rsp.w1}, {1'b1, diag_pkg::FN_DIAG, sub, exp});
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // ---------------------------------------------------------------
   // watchdog: the wrap run dominates at about 66k cycles
   // ---------------------------------------------------------------
   initial begin
      #(25 * 90000);
      fail_count++;
      complete_run();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge sys_clk);
      rst_b <= 1'b1;
      // power-up state and counters
      check("port idle", {listen_only, tx_ctrl_en, wdog_expire, delim}, {3'b010, diag_pkg::DELIM_RST});
      for (int i = 0; i < diag_pkg::N_CNT; i++) begin
         apb_xfer(1'b0, diag_pkg::A_CNT_BASE + 8'(4 * i), 32'h0);
         check("counter at reset", rd, 32'h0);
      end
      apb_xfer(1'b0, 8'h30, 32'h0);
      check("unmapped error", {31'h0, err}, 32'h1);
      // new delimiter, then fetches that must not count themselves
      diag(diag_pkg::SF_DELIM, 16'h3a00, 16'h3a00);
      check("delimiter", delim, 32'h3a);
      fetch(diag_pkg::STATUS_IDLE, 16'h0001);
      fetch(diag_pkg::STATUS_IDLE, 16'h0001);
      // a sub-function this block does not own is passed on, not answered
      diag_client_model_i.send(diag_pkg::FN_DIAG, 16'h0002, 16'h0000);
      check("forwarded", {fwd_valid, rsp_valid, fwd.sub}, {2'b10, 16'h0002});
      // program busy shows as all ones
      apb_xfer(1'b1, diag_pkg::A_CTRL, 32'h1);
      fetch(diag_pkg::STATUS_BUSY, 16'h0001);
      apb_xfer(1'b1, diag_pkg::A_CTRL, 32'h0);
      // clear counters and the diagnostic register
      apb_xfer(1'b1, diag_pkg::A_DIAG, 32'h1234);
      apb_xfer(1'b0, diag_pkg::A_DIAG, 32'h0);
      check("diag register", rd, 32'h1234);
      diag(diag_pkg::SF_CLEAR, diag_pkg::DATA_ZERO, diag_pkg::DATA_ZERO);
      apb_xfer(1'b0, diag_pkg::A_DIAG, 32'h0);
      check("diag cleared", rd, 32'h0);
      fetch(diag_pkg::STATUS_IDLE, 16'h0000);
      // every line event except ok_done once, then each count but the server count through its sub-function
      diag_client_model_i.pulse(8'hfe, 1);
      for (int i = 0; i < diag_pkg::N_CNT; i++) begin
         if (i != diag_pkg::CNT_SRV) diag(diag_pkg::SF_CNT_LO + 16'(i), 16'h0, 16'h0001);
      end
      // server count: the clear counts itself, then one fetch and seven queries
      diag(16'h000e, 16'h0, 16'h0009);
      // overrun counter and flag
      apb_xfer(1'b0, diag_pkg::A_STAT, 32'h0);
      check("overrun flag set", 32'(rd[diag_pkg::STAT_OVR_BIT]), 32'h1);
      diag(diag_pkg::SF_CLROVR, diag_pkg::DATA_ZERO, diag_pkg::DATA_ZERO);
      apb_xfer(1'b0, diag_pkg::A_CNT_LAST, 32'h0);
      check("overrun count", rd, 32'h0);
      apb_xfer(1'b0, diag_pkg::A_STAT, 32'h0);
      check("overrun flag clear", 32'(rd[diag_pkg::STAT_OVR_BIT]), 32'h0);
      // crc count driven past its wrap: 1 + 65537 leaves 2
      diag_client_model_i.pulse(8'h40, 65537);
      diag(16'h000c, 16'h0, 16'h0002);
      // ce low freezes the counters, so these crc pulses are lost
      @(posedge sys_clk);
      ce <= 1'b0;
      diag_client_model_i.pulse(8'h40, 3);
      ce <= 1'b1;
      diag(16'h000c, 16'h0, 16'h0002);
      // listen only: silent entry, event byte, controls off
      diag_client_model_i.send(diag_pkg::FN_DIAG, diag_pkg::SF_LISTEN, diag_pkg::DATA_ZERO);
      check("listen entry reply", 32'(rsp_valid), 32'h0);
      check("listen event", {evt_valid, evt_byte}, {1'b1, diag_pkg::EVT_LISTEN});
      check("listen controls", {listen_only, tx_ctrl_en, wdog_expire}, 32'h5);
      diag_client_model_i.send(diag_pkg::FN_DIAG, 16'h000c, 16'h0);
      check("listen ignores", {rsp_valid, fwd_valid}, 32'h0);
      diag_client_model_i.send(diag_pkg::FN_DIAG, diag_pkg::SF_RESTART, 16'h0);
      check("restart silent", {rsp_valid, port_restart}, 32'h1);
      @(posedge sys_clk);
      check("listen left", {listen_only, tx_ctrl_en, wdog_expire}, 32'h2);
      fetch(diag_pkg::STATUS_IDLE, 16'h0000);
      complete_run();
   end
endmodule
